/* core/osf_frame_fault.sv */
/*
 Sub-rated frame fault check in the line module. The framer side keeps the
 full-rate frame interface; this block only adds the subrate checks and
 the forced alarm signals. Assumes frame strobes come from logic on clock;
 AIS detection is supplied by the payload path as a per-frame flag.
 Slot maps and counts must be valid in the cycle of their frame strobe.
 A received or configured count of zero reads as an unreduced frame.
 The block raises alarm requests only; the AIS pattern itself is made
 downstream, so the framer-facing data path stays untouched.
*/
//
// Summary of operation
// RULE1 - Frame holds n overhead instances plus M slots of 5 Gbit/s.
// RULE2 - Expected M of zero means full 20 times n slots.
// RULE3 - Line rate scales by (10n+119M)/(10n+119*20n) of full rate.
// RULE4 - Source side checks every available slot is carried.
// RULE5 - An available slot not carried forces far-end AIS output.
// RULE6 - Sink side compares received and expected config; mismatch gives AIS.
// RULE7 - Incoming AIS on source side also forces far-end AIS.
// RULE8 - Framer interface unchanged; subrate handling stays in this module.
// RULE9 - Expected M and slot map held as config, checked once per frame.
`timescale 1ns/1ns
module osf_frame_fault #(
  parameter int TS = osf_pkg::TS_MAX
) (
  // Clock and reset
  input wire logic clock,
  input wire logic resetn,
  // Configuration
  input wire logic [osf_pkg::N_W-1:0] cfg_n,
  input wire logic [osf_pkg::TS_W-1:0] cfg_exp_m,
  input wire logic [TS-1:0] cfg_exp_map,
  input wire logic cfg_load,
  // Source direction
  input wire logic tx_frame_start,
  input wire logic [TS-1:0] tx_avail_map,
  input wire logic [TS-1:0] tx_carried_map,
  input wire logic tx_ais_in,
  // Sink direction
  input wire logic rx_frame_start,
  input wire logic [osf_pkg::TS_W-1:0] rx_m,
  input wire logic [TS-1:0] rx_map,
  // Results
  output logic far_ais_req,
  output logic sink_ais_out,
  output logic avail_fault,
  output logic mismatch_fault,
  output logic [osf_pkg::TS_W-1:0] eff_m,
  output logic [osf_pkg::RATE_W-1:0] rate_num,
  output logic [osf_pkg::RATE_W-1:0] rate_den
);

  ////////////////////////////////////////////////////////////////////////
  // Configuration hold

  logic [osf_pkg::N_W-1:0] n_r, n_nxt;
  logic [osf_pkg::TS_W-1:0] m_r, m_nxt;
  logic [TS-1:0] map_r, map_nxt;

  function automatic logic [osf_pkg::TS_W-1:0] full_m(
    input logic [osf_pkg::N_W-1:0] n
  );
    full_m = osf_pkg::TS_W'(n * osf_pkg::TS_PER_INST);
  endfunction

  // Unset M stands for the full slot complement of n instances
  function automatic logic [osf_pkg::TS_W-1:0] eff_count(
    input logic [osf_pkg::TS_W-1:0] m,
    input logic [osf_pkg::N_W-1:0] n
  );
    eff_count = (m == '0) ? full_m(n) : m;
  endfunction

  always_comb begin
    n_nxt = n_r;
    m_nxt = m_r;
    map_nxt = map_r;
    if (cfg_load) begin // see RULE9
      n_nxt = (cfg_n == '0) ? osf_pkg::N_RST : cfg_n;
      m_nxt = cfg_exp_m;
      map_nxt = cfg_exp_map;
    end
  end

  always_ff @(posedge clock) begin
    if (!resetn) begin
      n_r <= osf_pkg::N_RST;
      m_r <= osf_pkg::EXP_M_RST;
      map_r <= '0;
    end else begin
      n_r <= n_nxt;
      m_r <= m_nxt;
      map_r <= map_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Effective slot count and rate ratio

  logic [osf_pkg::TS_W-1:0] eff_m_nxt;
  logic [osf_pkg::RATE_W-1:0] num_nxt, den_nxt;

  always_comb begin
    // Unset M means an unreduced frame, see RULE2
    eff_m_nxt = eff_count(m_r, n_r);
    // Overhead per instance plus M slots, see RULE1
    num_nxt = osf_pkg::RATE_W'(osf_pkg::RATE_OH_MUL * n_r
              + osf_pkg::RATE_TS_MUL * eff_m_nxt); // see RULE3
    den_nxt = osf_pkg::RATE_W'(osf_pkg::RATE_OH_MUL * n_r
              + osf_pkg::RATE_TS_MUL * full_m(n_r)); // see RULE3
  end

  always_ff @(posedge clock) begin
    if (!resetn) begin
      eff_m <= '0;
      rate_num <= '0;
      rate_den <= '0;
    end else begin
      eff_m <= eff_m_nxt;
      rate_num <= num_nxt;
      rate_den <= den_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Slot checks

  logic avail_lost, map_mismatch;
  logic [osf_pkg::TS_W-1:0] rx_eff_m;

  // Received count of zero read like the configured one, see RULE2
  assign rx_eff_m = eff_count(rx_m, n_r);
  // Carried count left open: the source check needs the set, not its size

  osf_slot_cmp #(
    .TS(TS)
  ) u_cmp (
    .avail_map(tx_avail_map),
    .carried_map(tx_carried_map),
    .exp_map(map_r),
    .rx_map(rx_map),
    .avail_lost(avail_lost),
    .map_mismatch(map_mismatch),
    .carried_cnt()
  );

  ////////////////////////////////////////////////////////////////////////
  // Per-frame verdicts; held until the next frame of the same direction

  logic avail_nxt, mism_nxt, tx_ais_r, tx_ais_nxt;

  always_comb begin
    avail_nxt = avail_fault;
    tx_ais_nxt = tx_ais_r;
    mism_nxt = mismatch_fault;
    // All-ones payload hides slots, so slot check is skipped, see RULE7
    if (tx_frame_start) begin
      tx_ais_nxt = tx_ais_in;
      avail_nxt = !tx_ais_in && avail_lost; // see RULE4
    end
    if (rx_frame_start) begin // see RULE9
      mism_nxt = (rx_eff_m != eff_m_nxt) || map_mismatch; // see RULE6
    end
  end

  always_ff @(posedge clock) begin
    if (!resetn) begin
      avail_fault <= 1'b0;
      tx_ais_r <= 1'b0;
      mismatch_fault <= 1'b0;
    end else begin
      avail_fault <= avail_nxt;
      tx_ais_r <= tx_ais_nxt;
      mismatch_fault <= mism_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Alarm state; recovers only at a clean frame boundary

  osf_pkg::osf_state_t st_r, st_nxt;

  always_comb begin
    st_nxt = st_r;
    case (st_r)
      osf_pkg::OSF_IDLE: begin
        if (tx_frame_start || rx_frame_start) begin
          st_nxt = osf_pkg::OSF_RUN;
        end
      end
      osf_pkg::OSF_RUN: begin
        if (avail_fault || tx_ais_r || mismatch_fault) begin
          st_nxt = osf_pkg::OSF_AIS;
        end
      end
      osf_pkg::OSF_AIS: begin
        // Next flags, so recovery does not lag a clean frame
        if (!(avail_nxt || tx_ais_nxt || mism_nxt)) begin
          st_nxt = osf_pkg::OSF_RUN;
        end
      end
      default: st_nxt = osf_pkg::OSF_IDLE;
    endcase
  end

  always_ff @(posedge clock) begin
    if (!resetn) begin
      st_r <= osf_pkg::OSF_IDLE;
    end else begin
      st_r <= st_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Alarm outputs

  // Flags cannot rise before the first frame; the gate states it plainly
  logic alarm_armed;

  assign alarm_armed = (st_r != osf_pkg::OSF_IDLE);
  // Only alarm flags, eff_m and the rate terms leave; framer-facing data is untouched, see RULE8
  assign far_ais_req = alarm_armed && (avail_fault || tx_ais_r); // see RULE5
  assign sink_ais_out = alarm_armed && mismatch_fault; // see RULE6

endmodule

/* core/osf_pkg.sv */
/*
 Package for the sub-rated frame fault check: widths, defaults and the
 rate-scaling constants of the checker; its slot comparator uses only the slot widths.
 Assumes nothing of its surroundings.
*/
package osf_pkg;

  // Instances of overhead and slots per instance at full rate
  localparam int N_MAX = 4;
  localparam int TS_PER_INST = 20;
  localparam int TS_MAX = N_MAX * TS_PER_INST;
  localparam int TS_W = 7;
  localparam int N_W = 3;

  // Rate scaling terms: (10n + 119*M) / (10n + 119*20*n)
  localparam int RATE_OH_MUL = 10;
  localparam int RATE_TS_MUL = 119;
  localparam int TS_RATE_GBPS = 5;
  localparam int RATE_W = 16;

  // Reset values
  localparam logic [TS_W-1:0] EXP_M_RST = 7'h00;
  localparam logic [N_W-1:0] N_RST = 3'h1;

  typedef enum logic [1:0] {
    OSF_IDLE = 2'b00,
    OSF_RUN = 2'b01,
    OSF_AIS = 2'b10
  } osf_state_t;

endpackage

/* core/osf_slot_cmp.sv */
/*
 Slot comparator: checks that every slot flagged available is carried,
 counts carried slots and compares the received map with the expected set.
 Assumes all inputs are already on the checker's clock.
*/
`timescale 1ns/1ns
module osf_slot_cmp #(
  parameter int TS = osf_pkg::TS_MAX
) (
  // Slot maps
  input wire logic [TS-1:0] avail_map,
  input wire logic [TS-1:0] carried_map,
  input wire logic [TS-1:0] exp_map,
  input wire logic [TS-1:0] rx_map,
  // Results
  output logic avail_lost,
  output logic map_mismatch,
  output logic [osf_pkg::TS_W-1:0] carried_cnt
);

  always_comb begin
    carried_cnt = '0;
    for (int i = 0; i < TS; i++) begin
      carried_cnt = carried_cnt + osf_pkg::TS_W'(carried_map[i]);
    end
  end

  // Any slot marked available but not carried, see RULE4
  assign avail_lost = |(avail_map & ~carried_map);
  assign map_mismatch = (exp_map != rx_map);

endmodule

/* tb/osf_sva.sv */
/* Assertions for osf_frame_fault.
   Bound in tb_top onto the block's own ports. */
`timescale 1ns/1ns
module osf_sva #(
  parameter int TS = 80
) (
  // Clock and stimulus
  input wire logic clock,
  input wire logic resetn,
  input wire logic [6:0] cfg_exp_m,
  input wire logic cfg_load,
  input wire logic tx_frame_start,
  input wire logic [TS-1:0] tx_avail_map,
  input wire logic [TS-1:0] tx_carried_map,
  input wire logic tx_ais_in,
  input wire logic rx_frame_start,
  input wire logic [6:0] rx_m,
  // Results
  input wire logic far_ais_req,
  input wire logic sink_ais_out,
  input wire logic avail_fault,
  input wire logic mismatch_fault,
  input wire logic [6:0] eff_m,
  input wire logic [15:0] rate_num,
  input wire logic [15:0] rate_den
);
  default clocking @(posedge clock);
  endclocking
  default disable iff (!resetn);
  wire lost = |(tx_avail_map & ~tx_carried_map);
  a_ais_forces: assert property (tx_frame_start && tx_ais_in
    |=> far_ais_req && !avail_fault) else $error("AIS not forwarded");
  a_slot_lost: assert property (tx_frame_start && !tx_ais_in && lost
    |=> avail_fault && far_ais_req) else $error("lost slot missed");
  a_slot_ok: assert property (tx_frame_start && !tx_ais_in && !lost
    |=> !avail_fault) else $error("false slot fault");
  a_sink_ais: assert property (!rx_frame_start
    |=> $stable(sink_ais_out)) else $error("sink AIS moved between frames");
  a_rx_count: assert property (rx_frame_start && rx_m != 0
    && rx_m != eff_m |=> mismatch_fault) else $error("count mismatch missed");
  a_rate_ratio: assert property (rate_num == rate_den / 2390 * 10
    + 119 * eff_m) else $error("rate terms wrong");
  a_cfg_count: assert property (cfg_load && cfg_exp_m != 0
    |-> ##2 eff_m == $past(cfg_exp_m, 2)) else $error("M not loaded");
  a_full_rate: assert property (cfg_load && cfg_exp_m == 0
    |-> ##2 eff_m == rate_den / 2390 * 20) else $error("full M wrong");
endmodule

/* tb/osf_peer.sv */
/* Peer transponder sending sink frames.
   Hold has run out after the strobe, so fields flip. */
`timescale 1ns/1ns
module osf_peer (
  // Clock and request
  input wire logic clock,
  input wire logic go,
  input wire logic [6:0] m,
  input wire logic [79:0] map,
  // Sink frame
  output logic rx_frame_start,
  output logic [6:0] rx_m,
  output logic [79:0] rx_map
);
  initial {rx_frame_start, rx_m, rx_map} = '0;
  always @(posedge clock) begin
    rx_frame_start <= go;
    rx_m <= go ? m : ~rx_m;
    rx_map <= go ? map : ~rx_map;
  end
endmodule

/* tb/tb_top.sv */
/* Bench for osf_frame_fault with osf_peer on the sink side.
   Assumes default TS of 80 slots. */
`timescale 1ns/1ns
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin failures++; \
  $display("CHECK FAILED %0t mismatch", $time); end end
module tb_top;
  logic clock = 0, resetn = 0, cfg_load = 0, tx_frame_start = 0, go = 0;
  logic tx_ais_in = 0, rx_frame_start, far_ais_req, sink_ais_out;
  logic avail_fault, mismatch_fault;
  logic [2:0] cfg_n = 3'h2;
  logic [6:0] cfg_exp_m = 7'h19, pm = 7'h19, rx_m, eff_m;
  logic [79:0] cfg_exp_map = 80'hff, pmap = 80'hff, rx_map;
  logic [79:0] tx_avail_map = '0, tx_carried_map = '0;
  logic [15:0] rate_num, rate_den;
  int failures = 0, total_checks = 0;
  // Rows: AIS in, available, carried, expected slot fault
  logic [161:0] rows [4] = '{{1'h0, 80'hff, 80'hff, 1'h0},
    {1'h0, 80'hff, 80'h1ff, 1'h0},
    {1'h0, 80'h8000_0000_0000_0000_0000, 80'h7f, 1'h1},
    {1'h1, 80'hff, 80'h0, 1'h0}};
  osf_frame_fault dut (.clock(clock), .resetn(resetn), .cfg_n(cfg_n),
    .cfg_exp_m(cfg_exp_m), .cfg_exp_map(cfg_exp_map), .cfg_load(cfg_load),
    .tx_frame_start(tx_frame_start), .tx_avail_map(tx_avail_map),
    .tx_carried_map(tx_carried_map), .tx_ais_in(tx_ais_in),
    .rx_frame_start(rx_frame_start), .rx_m(rx_m), .rx_map(rx_map),
    .far_ais_req(far_ais_req), .sink_ais_out(sink_ais_out),
    .avail_fault(avail_fault), .mismatch_fault(mismatch_fault),
    .eff_m(eff_m), .rate_num(rate_num), .rate_den(rate_den));
  osf_peer peer (.clock(clock), .go(go), .m(pm), .map(pmap),
    .rx_frame_start(rx_frame_start), .rx_m(rx_m), .rx_map(rx_map));
  always #20 clock = ~clock;
  ////////////////////////////////////////////////////////////////////////
  task automatic cfg(input logic [2:0] n, input logic [6:0] m, input int e);
    int nn;
    nn = (n == 0) ? 1 : n;
    @(posedge clock);
    {cfg_n, cfg_exp_m, cfg_load} <= {n, m, 1'h1};
    @(posedge clock);
    cfg_load <= 0;
    repeat (2) @(posedge clock);
    #1;
    `CHK(eff_m, 7'(e))
    `CHK(rate_num, 16'(10 * nn + 119 * e))
    `CHK(rate_den, 16'(2390 * nn))
    $display("cfg done");
  endtask
  task automatic tx(input logic [161:0] r);
    @(posedge clock);
    {tx_ais_in, tx_avail_map, tx_carried_map} <= r[161:1];
    tx_frame_start <= 1'h1;
    @(posedge clock);
    tx_frame_start <= 0;
    #1;
    `CHK(avail_fault, r[0])
    `CHK(far_ais_req, r[0] | r[161])
    $display("tx done");
  endtask
  task automatic rx(input logic [6:0] m, input logic [79:0] mp, logic e);
    @(posedge clock);
    {pm, pmap, go} <= {m, mp, 1'h1};
    @(posedge clock);
    go <= 0;
    @(posedge clock);
    #1;
    `CHK(mismatch_fault, e)
    `CHK(sink_ais_out, e)
    $display("rx done");
  endtask
  task automatic close_out;
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    repeat (3) @(posedge clock);
    resetn <= 1;
    @(posedge clock);
    #1;
    `CHK(eff_m, 7'h14)
    cfg(3'h2, 7'h19, 25);
    foreach (rows[i]) tx(rows[i]);
    rx(7'h19, 80'hff, 0);
    rx(7'h1e, 80'hff, 1);
    rx(7'h19, 80'hfe, 1);
    rx(7'h19, 80'hff, 0);
    cfg(3'h0, 7'h00, 20);
    rx(7'h14, 80'hff, 0);
    rx(7'h00, 80'hff, 0);
    rx(7'h01, 80'hff, 1);
    @(posedge clock);
    resetn <= 0;
    @(posedge clock);
    #1;
    `CHK(mismatch_fault, 1'h0)
    `CHK(far_ais_req, 1'h0)
    `CHK(eff_m, 7'h00)
    @(posedge clock);
    resetn <= 1;
    @(posedge clock);
    #1;
    `CHK(eff_m, 7'h14)
    `CHK(rate_den, 16'h0956)
    $display("reset done");
    close_out;
  end
  initial begin
    #100000;
    failures++;
    close_out;
  end
endmodule
bind osf_frame_fault osf_sva #(.TS(TS)) u_sva (.clock(clock),
  .resetn(resetn), .cfg_exp_m(cfg_exp_m), .cfg_load(cfg_load),
  .tx_frame_start(tx_frame_start), .tx_avail_map(tx_avail_map),
  .tx_carried_map(tx_carried_map), .tx_ais_in(tx_ais_in),
  .rx_frame_start(rx_frame_start), .rx_m(rx_m),
  .far_ais_req(far_ais_req), .sink_ais_out(sink_ais_out),
  .avail_fault(avail_fault), .mismatch_fault(mismatch_fault),
  .eff_m(eff_m), .rate_num(rate_num), .rate_den(rate_den));
